// ### hdl/logic_block_regs.svh
// Bit positions, widths and sizes of the configurable logic block
`ifndef LOGIC_BLOCK_REGS_SVH
`define LOGIC_BLOCK_REGS_SVH

// ****************************************************************
// Block geometry
// ****************************************************************
`define LB_CELLS      4
`define LB_SLICES     2
`define LB_LUT_DEPTH  16
`define LB_LUT_ABITS  4

// ****************************************************************
// Positions inside the synchronised pin vector
// ****************************************************************
`define IN_ADDR    0
`define IN_WE      16
`define IN_WDATA   18
`define IN_FEED    22
`define IN_CIN     26
`define IN_SCLK    28
`define IN_CE      30
`define IN_INIT    32
`define IN_OPP     34
`define IN_F6SEL   36
`define IN_BUSD    37
`define IN_BUSEN   39
`define IN_W       41

// ****************************************************************
// Positions inside each slice polarity-inversion field
// ****************************************************************
`define INV_CLK    0
`define INV_CE     1
`define INV_INIT   2
`define INV_OPP    3

// ****************************************************************
// Reset values
// ****************************************************************
`define LUT_RST    16'h0000

`endif

// ### hdl/logic_block_pkg.sv
// Types shared by the configurable logic block and its bench
package logic_block_pkg;
`include "logic_block_regs.svh"

    // ****************************************************************
    // Lookup table operating modes, one per slice
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_LOGIC   = 3'h0,
        MODE_RAM16X1 = 3'h1,
        MODE_RAM16X2 = 3'h3,
        MODE_RAM32X1 = 3'h2,
        MODE_RAM_DP  = 3'h6,
        MODE_SHIFT   = 3'h7
    } lut_mode_t;

    // ****************************************************************
    // Whole state of the block, registered as one word
    // ****************************************************************
    typedef struct packed {
        logic [`IN_W-1:0]                          sync1;
        logic [`IN_W-1:0]                          sync2;
        logic [`LB_SLICES-1:0]                     clk_prev;
        logic [`LB_CELLS-1:0][`LB_LUT_DEPTH-1:0]   mem;
        logic [`LB_CELLS-1:0]                      q;
        logic [`LB_CELLS-1:0]                      lookup_table;
        logic [`LB_CELLS-1:0]                      sum;
        logic [`LB_SLICES-1:0]                     f5;
        logic                                      f6;
        logic [`LB_SLICES-1:0]                     cout;
        logic [`LB_CELLS-1:0]                      feed;
        logic [1:0]                                bus;
        logic [1:0]                                bus_oe;
    } lb_state_t;

endpackage : logic_block_pkg

// ### hdl/logic_block.sv
// One configurable logic block: two slices of two logic cells each
//
// Functional notes
// R1: Cell has 4-input table, carry, storage
// R2: Table output feeds output and storage D
// R3: Four cells in two identical slices
// R4: Table may act as 16x1 synchronous memory
// R5: Slice memory 16x2, 32x1 or dual-port
// R6: Table may act as 16-stage shift register
// R7: Storage is flip-flop or transparent latch
// R8: Storage D from table or direct input
// R9: Init force loads configured initial value
// R10: Opposite force loads inverted initial value
// R11: Forces synchronous, optionally asynchronous per slice
// R12: Clock, enable, forces each invertible
// R13: Slice controls shared by both storage elements
// R14: Five-input mux picks between slice tables
// R15: Six-input mux picks between five-input muxes
// R16: Four feedthrough paths, two per slice
// R17: Two independent carry chains, one per slice
// R18: Carry advances two bits per block
// R19: Dedicated XOR gives 2-bit adder per slice
// R20: Dedicated AND gate for partial products
// R21: Carry path cascades tables into wide logic
// R22: Two tristate bus drivers, own data, enable
// R23: Memory writes on edge, reads combinationally
// R24: Shift one per enabled edge, tap by address
`timescale 1ns/1ps

module logic_block (
    // Clock and reset
    input  wire logic                               clk_in,
    input  wire logic                               rst_in,
    // Configuration, static after load
    input  wire logic_block_pkg::lut_mode_t [1:0]   cfg_mode_in,
    input  wire logic [3:0][15:0]                   cfg_lut_init_in,
    input  wire logic                               cfg_load_in,
    input  wire logic [1:0]                         cfg_latch_in,
    input  wire logic [1:0]                         cfg_async_in,
    input  wire logic [1:0][3:0]                    cfg_inv_in,
    input  wire logic [3:0]                         cfg_init_val_in,
    input  wire logic [3:0]                         cfg_d_bypass_in,
    input  wire logic [1:0]                         cfg_and_in,
    // Cell pins from routing
    input  wire logic [15:0]                        cell_addr_in,
    input  wire logic [3:0]                         cell_wdata_in,
    input  wire logic [3:0]                         feedthrough_in,
    // Slice control pins
    input  wire logic [1:0]                         slice_clk_in,
    input  wire logic [1:0]                         slice_ce_in,
    input  wire logic [1:0]                         slice_we_in,
    input  wire logic [1:0]                         slice_init_force_in,
    input  wire logic [1:0]                         slice_opposite_force_in,
    input  wire logic [1:0]                         carry_in,
    input  wire logic                               six_input_mux_sel_in,
    // Tristate bus driver pins
    input  wire logic [1:0]                         bus_data_in,
    input  wire logic [1:0]                         bus_en_in,
    // Cell and slice results
    output logic [3:0]                              lookup_table_out,
    output logic [3:0]                              sum_out,
    output logic [3:0]                              q_out,
    output logic [3:0]                              feedthrough_out,
    output logic [1:0]                              five_input_mux_out,
    output logic                                    six_input_mux_out,
    output logic [1:0]                              carry_out,
    // Tristate bus driver outputs
    output logic [1:0]                              tristate_bus_driver_out,
    output logic [1:0]                              tristate_bus_driver_oe_out
);
    import logic_block_pkg::*;

    lb_state_t st_r;
    lb_state_t st_nxt;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Read one bit of a sixteen-entry table at a four-bit address
    function automatic logic table_bit(input logic [15:0] word,
                                       input logic [3:0]  addr);
        table_bit = word[addr];
    endfunction : table_bit

    // Apply a configured inversion to a control pin
    function automatic logic polar(input logic lvl,
                                   input logic inv);
        polar = lvl ^ inv;
    endfunction : polar

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // All pins are resampled twice; every decision below uses sync2 only
    always_comb begin
        logic [`IN_W-1:0] pin;
        logic [1:0]       clk_lvl;
        logic [1:0]       clk_edge;
        logic [1:0]       ce;
        logic [1:0]       init_f;
        logic [1:0]       opp_f;
        logic [3:0][3:0]  addr;
        logic [3:0][3:0]  rd_addr;
        logic [3:0]       lookup_table;
        logic [3:0]       d;
        logic [3:0]       wd;
        logic [3:0]       feed;
        logic [1:0]       f5;
        logic             ci;
        logic             di;
        logic [3:0]       sum;
        logic [1:0]       co;
        logic             force_val;
        int               b;
        pin      = st_r.sync2;
        clk_lvl  = '0;
        clk_edge = '0;
        ce       = '0;
        init_f   = '0;
        opp_f    = '0;
        addr     = '0;
        rd_addr  = '0;
        lookup_table      = '0;
        d        = '0;
        wd       = pin[`IN_WDATA +: 4];
        feed     = pin[`IN_FEED +: 4];
        f5       = '0;
        ci       = 1'b0;
        di       = 1'b0;
        sum      = '0;
        co       = '0;
        force_val = 1'b0;
        b        = 0;
        st_nxt   = st_r;

        // Two-stage resampling of every pin
        st_nxt.sync1 = {bus_en_in, bus_data_in, six_input_mux_sel_in,
                        slice_opposite_force_in, slice_init_force_in,
                        slice_ce_in, slice_clk_in, carry_in,
                        feedthrough_in, cell_wdata_in, slice_we_in,
                        cell_addr_in};
        st_nxt.sync2 = st_r.sync1;

        // Slice controls with their polarity; shared by both cells
        for (int s = 0; s < `LB_SLICES; s++) begin
            clk_lvl[s] = polar(pin[`IN_SCLK + s],
                               cfg_inv_in[s][`INV_CLK]);        // [R12]
            ce[s]      = polar(pin[`IN_CE + s],
                               cfg_inv_in[s][`INV_CE]);         // [R12]
            init_f[s]  = polar(pin[`IN_INIT + s],
                               cfg_inv_in[s][`INV_INIT]);       // [R12]
            opp_f[s]   = polar(pin[`IN_OPP + s],
                               cfg_inv_in[s][`INV_OPP]);        // [R12]
            // Slice clock becomes a one-cycle enable on its active edge
            clk_edge[s] = clk_lvl[s] & ~st_r.clk_prev[s];
        end
        st_nxt.clk_prev = clk_lvl;

        // Table read addresses; 16x2 and 32x1 modes share the first cell address
        for (int c = 0; c < `LB_CELLS; c++) begin
            b       = (c / 2) * 2;
            addr[c] = pin[`IN_ADDR + 4*c +: 4];
        end
        for (int c = 0; c < `LB_CELLS; c++) begin
            b = (c / 2) * 2;
            case (cfg_mode_in[c / 2])
                MODE_RAM16X2,
                MODE_RAM32X1: rd_addr[c] = addr[b];              // [R5]
                default:      rd_addr[c] = addr[c];              // [R24]
            endcase
            // Combinational read of the current contents
            lookup_table[c] = table_bit(st_r.mem[c], rd_addr[c]);         // [R1] [R23]
        end

        // Wide-function multiplexers
        for (int s = 0; s < `LB_SLICES; s++) begin
            // The first feedthrough of the slice steers its mux
            f5[s] = feed[2*s] ? lookup_table[2*s+1] : lookup_table[2*s];           // [R14]
        end

        // Carry chains: two cells per slice, then on to the next block
        for (int s = 0; s < `LB_SLICES; s++) begin
            ci = pin[`IN_CIN + s];                               // [R17]
            for (int k = 0; k < 2; k++) begin
                b = 2*s + k;
                // AND of two address bits forms a partial product
                di = cfg_and_in[s] ? (addr[b][0] & addr[b][1])
                                   : addr[b][0];                 // [R20]
                sum[b] = lookup_table[b] ^ ci;                            // [R19]
                // Propagate selects carry; with di low this is a wide AND
                ci = lookup_table[b] ? ci : di;                           // [R18] [R21]
            end
            co[s] = ci;
        end

        // Memory and shift writes on the active slice edge
        for (int s = 0; s < `LB_SLICES; s++) begin
            b = 2*s;
            if (clk_edge[s]) begin
                case (cfg_mode_in[s])
                    MODE_RAM16X1: begin
                        if (pin[`IN_WE + s]) begin
                            st_nxt.mem[b][addr[b]]     = wd[b];    // [R4] [R23]
                            st_nxt.mem[b+1][addr[b+1]] = wd[b+1];  // [R4] [R23]
                        end
                    end
                    MODE_RAM16X2: begin
                        if (pin[`IN_WE + s]) begin
                            st_nxt.mem[b][addr[b]]   = wd[b];      // [R5]
                            st_nxt.mem[b+1][addr[b]] = wd[b+1];    // [R5]
                        end
                    end
                    MODE_RAM32X1: begin
                        // Fifth address bit picks which table is written
                        if (pin[`IN_WE + s]) begin
                            if (feed[b]) begin
                                st_nxt.mem[b+1][addr[b]] = wd[b];  // [R5]
                            end else begin
                                st_nxt.mem[b][addr[b]] = wd[b];    // [R5]
                            end
                        end
                    end
                    MODE_RAM_DP: begin
                        // Both copies written; second cell is the read port
                        if (pin[`IN_WE + s]) begin
                            st_nxt.mem[b][addr[b]]   = wd[b];      // [R5]
                            st_nxt.mem[b+1][addr[b]] = wd[b];      // [R5]
                        end
                    end
                    MODE_SHIFT: begin
                        if (ce[s]) begin
                            st_nxt.mem[b]   = {st_r.mem[b][14:0],
                                               wd[b]};             // [R6] [R24]
                            st_nxt.mem[b+1] = {st_r.mem[b+1][14:0],
                                               wd[b+1]};           // [R6] [R24]
                        end
                    end
                    default: begin
                        // Logic mode holds its configured contents
                    end
                endcase
            end
        end

        // Configuration load overrides any write in the same cycle
        if (cfg_load_in) begin
            st_nxt.mem = cfg_lut_init_in;
        end

        // Storage elements
        for (int c = 0; c < `LB_CELLS; c++) begin
            b = c / 2;
            d[c] = cfg_d_bypass_in[c] ? feed[c] : lookup_table[c];        // [R2] [R8]
            // Init force wins over the opposite force when both are high
            force_val = init_f[b] ? cfg_init_val_in[c]          // [R9]
                                  : ~cfg_init_val_in[c];        // [R10]
            if ((init_f[b] | opp_f[b]) &&
                (cfg_async_in[b] | clk_edge[b])) begin
                st_nxt.q[c] = force_val;                         // [R11] [R13]
            end else if (cfg_latch_in[b]) begin
                // Transparent while the slice clock level is active
                if (clk_lvl[b] & ce[b]) begin
                    st_nxt.q[c] = d[c];                          // [R7] [R13]
                end
            end else if (clk_edge[b] & ce[b]) begin
                st_nxt.q[c] = d[c];                              // [R7] [R13]
            end
        end

        // Registered results; this adds one cycle to every path
        st_nxt.lookup_table    = lookup_table;                                     // [R2] [R3]
        st_nxt.sum    = sum;
        st_nxt.f5     = f5;
        st_nxt.f6     = pin[`IN_F6SEL] ? f5[1] : f5[0];          // [R15]
        st_nxt.cout   = co;
        st_nxt.feed   = feed;                                    // [R16]
        st_nxt.bus    = pin[`IN_BUSD +: 2];                      // [R22]
        st_nxt.bus_oe = pin[`IN_BUSEN +: 2];                     // [R22]
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Tables clear and storage elements start low until configured
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r          <= '0;
            st_r.mem      <= {`LB_CELLS{`LUT_RST}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Every output but tristate_bus_driver_out is a flip-flop of the state word
    assign lookup_table_out           = st_r.lookup_table;
    assign sum_out                    = st_r.sum;
    assign q_out                      = st_r.q;
    assign feedthrough_out            = st_r.feed;
    assign five_input_mux_out         = st_r.f5;
    assign six_input_mux_out          = st_r.f6;
    assign carry_out                  = st_r.cout;
    // Data is driven low while disabled so the bus wire sees no X
    assign tristate_bus_driver_out    = st_r.bus & st_r.bus_oe;
    assign tristate_bus_driver_oe_out = st_r.bus_oe;

endmodule : logic_block

// ### test/logic_block_sva.sv
// Port-level assertions for the configurable logic block
`timescale 1ns/1ps

module logic_block_sva (
    // Clock and reset
    input wire logic            clk_in,
    input wire logic            rst_in,
    // Watched inputs
    input wire logic [1:0]      cfg_latch_in,
    input wire logic [1:0]      cfg_async_in,
    input wire logic [1:0][3:0] cfg_inv_in,
    input wire logic [3:0]      feedthrough_in,
    input wire logic [1:0]      slice_clk_in,
    input wire logic [1:0]      carry_in,
    input wire logic            six_input_mux_sel_in,
    input wire logic [1:0]      bus_data_in,
    input wire logic [1:0]      bus_en_in,
    // Watched outputs
    input wire logic [3:0]      lookup_table_out,
    input wire logic [3:0]      sum_out,
    input wire logic [3:0]      q_out,
    input wire logic [3:0]      feedthrough_out,
    input wire logic [1:0]      five_input_mux_out,
    input wire logic            six_input_mux_out,
    input wire logic [1:0]      tristate_bus_driver_out,
    input wire logic [1:0]      tristate_bus_driver_oe_out
);
    // ********
    // Helper state
    // ********
    logic [1:0]  warm_r;
    logic [11:0] hist_r;
    logic        moved;

    // Warm-up count hides the three-flop pin pipeline after reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            warm_r <= 2'h0;
            hist_r <= 12'h000;
        end else begin
            warm_r <= (warm_r == 2'h3) ? warm_r : warm_r + 2'h1;
            hist_r <= {hist_r[9:0], slice_clk_in[0], cfg_inv_in[0][0]};
        end
    end
    // Slice 0 clock level may have moved inside the sync window
    assign moved = (hist_r != {6{hist_r[1:0]}});

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // ********
    // Assertions
    // ********
    a_reset_clear: assert property (disable iff (1'b0)
        rst_in ##1 rst_in |-> q_out == 4'h0 && lookup_table_out == 4'h0)
        else $error("outputs not cleared in reset");
    a_bus_mask: assert property (
        (tristate_bus_driver_out & ~tristate_bus_driver_oe_out) == 2'h0)
        else $error("driver data while disabled");
    a_oe_delay: assert property (warm_r == 2'h3 |->
        tristate_bus_driver_oe_out == $past(bus_en_in, 3))
        else $error("driver enable wrong");
    a_bus_data: assert property (warm_r == 2'h3 |->
        tristate_bus_driver_out == $past(bus_data_in & bus_en_in, 3))
        else $error("driver data wrong");
    a_feed_delay: assert property (warm_r == 2'h3 |->
        feedthrough_out == $past(feedthrough_in, 3))
        else $error("feedthrough wrong");
    a_six_select: assert property (warm_r == 2'h3 |->
        six_input_mux_out == ($past(six_input_mux_sel_in, 3) ?
        five_input_mux_out[1] : five_input_mux_out[0]))
        else $error("six-input mux picked wrong input");
    a_sum_carry: assert property (warm_r == 2'h3 |->
        sum_out[0] == (lookup_table_out[0] ^ $past(carry_in[0], 3)))
        else $error("sum bit wrong");
    a_q_on_edge: assert property (
        cfg_latch_in[0] == 1'b0 && cfg_async_in[0] == 1'b0 &&
        $changed(q_out[1:0]) |-> moved)
        else $error("storage changed without slice clock");

    // Main scenarios reached
    c_q_change: cover property ($changed(q_out));
    c_bus_on: cover property (tristate_bus_driver_oe_out == 2'h3);
    c_six_high: cover property (six_input_mux_out);
endmodule : logic_block_sva

bind logic_block logic_block_sva chk (.clk_in, .rst_in, .cfg_latch_in,
    .cfg_async_in, .cfg_inv_in, .feedthrough_in, .slice_clk_in, .carry_in,
    .six_input_mux_sel_in, .bus_data_in, .bus_en_in, .lookup_table_out,
    .sum_out, .q_out, .feedthrough_out, .five_input_mux_out,
    .six_input_mux_out, .tristate_bus_driver_out,
    .tristate_bus_driver_oe_out);

// ### test/logic_block_test.sv
// Self-checking bench for the configurable logic block
`timescale 1ns/1ps

module logic_block_test;
    import logic_block_pkg::*;

    // ********
    // Bench signals
    // ********
    logic             clk_in = 1'b0;
    logic             rst_in = 1'b1;
    lut_mode_t [1:0]  mode;
    logic [3:0][15:0] init;
    logic [15:0]      addr;
    logic [1:0][3:0]  inv;
    logic [3:0]       ival, byp, wd, feed, lut_o, sum_o, q_o, feed_o;
    logic [1:0]       lat, asy, andg, sck, ce, we, fi, fo, cin, bd, be;
    logic [1:0]       f5_o, co_o, drv_o, oe_o, f5a;
    logic             load, f6s, f6_o;
    int               num_errors = 0;
    int               cmp_count = 0;

    // 50 MHz clock
    always #10 clk_in = ~clk_in;

    logic_block dut (.clk_in(clk_in), .rst_in(rst_in), .cfg_mode_in(mode),
        .cfg_lut_init_in(init), .cfg_load_in(load), .cfg_latch_in(lat),
        .cfg_async_in(asy), .cfg_inv_in(inv), .cfg_init_val_in(ival),
        .cfg_d_bypass_in(byp), .cfg_and_in(andg), .cell_addr_in(addr),
        .cell_wdata_in(wd), .feedthrough_in(feed), .slice_clk_in(sck),
        .slice_ce_in(ce), .slice_we_in(we), .slice_init_force_in(fi),
        .slice_opposite_force_in(fo), .carry_in(cin),
        .six_input_mux_sel_in(f6s), .bus_data_in(bd), .bus_en_in(be),
        .lookup_table_out(lut_o), .sum_out(sum_o), .q_out(q_o),
        .feedthrough_out(feed_o), .five_input_mux_out(f5_o),
        .six_input_mux_out(f6_o), .carry_out(co_o),
        .tristate_bus_driver_out(drv_o),
        .tristate_bus_driver_oe_out(oe_o));

    // ********
    // Shared tasks
    // ********
    task check(input string what, input logic [15:0] exp,
               input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask : tick

    // Slice clock pin held several cycles so the sampled edge is not lost
    task pulse;
        sck = ~sck;
        tick(3);
        sck = ~sck;
        tick(6);
    endtask : pulse

    task load_tab(input logic [3:0][15:0] v);
        init = v;
        load = 1'b1;
        tick(1);
        load = 1'b0;
        tick(5);
    endtask : load_tab

    // ********
    // Scenarios
    // ********
    // Every address of every table, then table value into storage
    task logic_cells;
        logic [3:0] e;
        load_tab({16'h00ff, 16'h0f0f, 16'h3333, 16'h5555});
        for (int a = 0; a < 16; a++) begin
            addr = {4{a[3:0]}};
            tick(5);
            for (int c = 0; c < 4; c++)
                e[c] = init[c][a];
            check("lookup_table_out", e, lut_o);
        end
        addr = 16'h6666;
        pulse;
        check("q_out", {init[3][6], init[2][6], init[1][6], init[0][6]},
              q_o);
    endtask : logic_cells

    // Bypass, enable, inversion, both forces, async and latch modes
    task storage;
        byp = 4'hf;
        feed = 4'ha;
        pulse;
        check("q_out", 4'ha, q_o);
        feed = 4'h5;
        ce = 2'b00;
        pulse;
        check("q_out", 4'ha, q_o);
        inv = {2{4'b0010}};
        pulse;
        check("q_out", 4'h5, q_o);
        inv = 8'h00;
        ce = 2'b11;
        ival = 4'h6;
        fi = 2'b11;
        tick(6);
        check("q_out", 4'h5, q_o);
        pulse;
        check("q_out", 4'h6, q_o);
        fi = 2'b00;
        fo = 2'b11;
        pulse;
        check("q_out", 4'h9, q_o);
        fo = 2'b00;
        asy = 2'b11;
        fi = 2'b11;
        tick(6);
        check("q_out", 4'h6, q_o);
        fi = 2'b00;
        tick(4);
        asy = 2'b00;
        lat = 2'b11;
        sck = 2'b11;
        tick(6);
        check("q_out", 4'h5, q_o);
        sck = 2'b00;
        tick(4);
        feed = 4'h3;
        tick(6);
        check("q_out", 4'h5, q_o);
        lat = 2'b00;
        // Inverting a low clock pin makes a rising edge
        inv = {2{4'b0001}};
        tick(6);
        check("q_out", 4'h3, q_o);
        inv = 8'h00;
        byp = 4'h0;
        tick(4);
    endtask : storage

    task mem_single;
        load_tab({4{16'h0000}});
        mode = '{MODE_RAM16X1, MODE_RAM16X1};
        addr = 16'h5555;
        wd = 4'hb;
        we = 2'b11;
        pulse;
        we = 2'b00;
        wd = 4'h4;
        pulse;
        check("lookup_table_out", 4'hb, lut_o);
        addr = 16'h4444;
        tick(5);
        check("lookup_table_out", 4'h0, lut_o);
    endtask : mem_single

    // Paired tables of slice 0: 16x2, dual-port, 32x1
    task mem_pairs;
        load_tab({4{16'h0000}});
        mode[0] = MODE_RAM16X2;
        addr = 16'h0093;
        wd = 4'h2;
        we = 2'b01;
        pulse;
        check("lookup_table_out", 4'h2, lut_o);
        load_tab({4{16'h0000}});
        mode[0] = MODE_RAM_DP;
        wd = 4'h1;
        pulse;
        check("lookup_table_out", 4'h1, lut_o);
        addr = 16'h0033;
        tick(5);
        check("lookup_table_out", 4'h3, lut_o);
        load_tab({4{16'h0000}});
        mode[0] = MODE_RAM32X1;
        feed = 4'h1;
        pulse;
        we = 2'b00;
        f5a = f5_o;
        feed = 4'h0;
        tick(5);
        check("five_input_mux_out", 2'b10, {f5a[0], f5_o[0]});
    endtask : mem_pairs

    task shift_mode;
        logic [4:0] sv;
        sv = 5'b01101;
        load_tab({4{16'h0000}});
        mode = '{MODE_SHIFT, MODE_SHIFT};
        for (int i = 0; i < 5; i++) begin
            wd = {4{sv[i]}};
            pulse;
        end
        ce = 2'b00;
        wd = 4'hf;
        pulse;
        ce = 2'b11;
        for (int a = 0; a < 5; a++) begin
            addr = {4{a[3:0]}};
            tick(5);
            check("lookup_table_out", {4{sv[4-a]}}, lut_o);
        end
    endtask : shift_mode

    // Carry propagate and generate, AND gate, then both wide muxes
    task arith;
        mode = '{MODE_LOGIC, MODE_LOGIC};
        load_tab({16'h0000, 16'h0000, 16'hffff, 16'hffff});
        addr = 16'h1000;
        cin = 2'b01;
        tick(6);
        check("carry_out", 2'b11, co_o);
        check("sum_out", 4'h0, sum_o);
        cin = 2'b00;
        andg = 2'b10;
        tick(6);
        check("carry_out", 2'b00, co_o);
        check("sum_out", 4'h3, sum_o);
        load_tab({16'hffff, 16'h0000, 16'h0000, 16'hffff});
        feed = 4'h0;
        tick(5);
        f5a = f5_o;
        feed = 4'h5;
        tick(5);
        check("five_input_mux_out", 2'b11, f5a ^ f5_o);
        feed = 4'h1;
        for (int s = 0; s < 2; s++) begin
            f6s = s[0];
            tick(5);
            check("six_input_mux_out", s == 0, f6_o ^ f5a[s]);
        end
    endtask : arith

    task bus_drv;
        for (int i = 0; i < 16; i++) begin
            {bd, be} = i[3:0];
            tick(5);
            check("driver_oe", be, oe_o);
            check("driver_data", bd & be, drv_o);
        end
    endtask : bus_drv

    task summarize;
        $display("errors %0d, comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // Main sequence: reset for three cycles, then every scenario
    initial begin
        mode = '{MODE_LOGIC, MODE_LOGIC};
        init = {4{16'h0000}};
        {load, f6s} = 2'b00;
        {lat, asy, andg, sck, we, fi, fo, cin, bd, be} = 20'h00000;
        ce = 2'b11;
        {inv, ival, byp, wd, feed} = 24'h000000;
        addr = 16'h0000;
        tick(3);
        rst_in = 1'b0;
        tick(2);
        check("q_out", 4'h0, q_o);
        logic_cells;
        storage;
        mem_single;
        mem_pairs;
        shift_mode;
        arith;
        bus_drv;
        summarize;
    end

    // Hang guard
    initial begin
        #2000000;
        num_errors++;
        summarize;
    end
endmodule : logic_block_test
